// >>> hw/link_test_pkg.sv
// Purpose: constants of the link coding block
// Assumes: byte address is four times the index
// Notes:   logic holds no bare register indices or codes
package link_test_pkg;
    // ==========================================================
    // register indices (byte address = index * 4)
    localparam logic [13:0] CTRL2_IDX    = 14'h0572;
    localparam logic [13:0] CTRL3_IDX    = 14'h0573;
    localparam logic [13:0] CFG_TAB_IDX  = 14'h0590;
    localparam logic [13:0] USER_PAT_IDX = 14'h0591;
    localparam logic [13:0] CHKSUM_IDX   = 14'h0592;
    localparam logic [7:0]  CTRL2_RST    = 8'h00;
    localparam logic [7:0]  CTRL3_RST    = 8'h00;
    localparam logic [31:0] CFG_TAB_RST  = 32'h0000_0000;
    localparam logic [31:0] USER_PAT_RST = 32'h0000_0000;
    // ==========================================================
    // control field positions
    localparam int BYPASS_BIT = 2;
    localparam int INVERT_BIT = 1;
    localparam int CSUM_HI    = 7;
    localparam int CSUM_LO    = 6;
    localparam int INJ_HI     = 5;
    localparam int INJ_LO     = 4;
    localparam int PAT_HI     = 3;
    localparam int PAT_LO     = 0;
    // ==========================================================
    // checksum modes and injection points
    localparam logic [1:0] CSUM_REGS   = 2'h0;
    localparam logic [1:0] CSUM_FIELDS = 2'h1;
    localparam logic [1:0] CSUM_ZERO   = 2'h2;
    localparam logic [1:0] INJ_SAMPLE  = 2'h0;
    localparam logic [1:0] INJ_SYMBOL  = 2'h1;
    localparam logic [1:0] INJ_SCRAM   = 2'h2;
    // ==========================================================
    // test pattern codes
    localparam logic [3:0] PAT_OFF    = 4'h0;
    localparam logic [3:0] PAT_CHECK  = 4'h1;
    localparam logic [3:0] PAT_TOGGLE = 4'h2;
    localparam logic [3:0] PAT_PN31   = 4'h3;
    localparam logic [3:0] PAT_PN23   = 4'h4;
    localparam logic [3:0] PAT_PN15   = 4'h5;
    localparam logic [3:0] PAT_PN9    = 4'h6;
    localparam logic [3:0] PAT_PN7    = 4'h7;
    localparam logic [3:0] PAT_RAMP   = 4'h8;
    localparam logic [3:0] PAT_USER_R = 4'he;
    localparam logic [3:0] PAT_USER_1 = 4'hf;
    localparam logic [30:0] PN_SEED   = 31'h7fff_ffff;
    // ==========================================================
    // configuration table field layout
    localparam int DID_LO = 0;
    localparam int BID_LO = 8;
    localparam int ADJ_LO = 12;
    localparam int LID_LO = 16;
    localparam int SCR_BIT = 23;
    localparam int LCNT_LO = 24;
    localparam int HD_BIT  = 31;
    // ==========================================================
    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : link_test_pkg

// >>> hw/pat_if.sv
// Purpose: pattern channel, control to generator
// Assumes: one clock
// Notes:   step advances, restart reloads
`timescale 1ns/10ps
interface pat_if #(parameter int W = 20);
    logic [3:0]   code;
    logic         step;
    logic         restart;
    logic [31:0]  user;
    logic [W-1:0] word;
    logic         active;
    modport ctrl (output code, step, restart, user, input word, active);
    modport gen  (input code, step, restart, user, output word, active);
endinterface : pat_if

// >>> hw/test_pattern_gen.sv
// Purpose: test pattern source
// Assumes: restart beats step
// Notes:   pn codes share one shift register
`timescale 1ns/10ps
module test_pattern_gen #(
    parameter int W = 20
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // pattern channel
    pat_if.gen        p
);
    import link_test_pkg::*;

    logic [30:0]  lfsr_reg;
    logic         ph_reg;
    logic [W-1:0] ramp_reg;
    logic         idx_reg;
    logic         done_reg;
    logic         sent_reg;
    logic [W-1:0] word_reg;
    logic [30:0]  lfsr_next;
    logic [W-1:0] prbs_word;
    logic [W-1:0] word_next;

    // ==========================================================
    // pn stepping: W bits per word, newest bit in the lsb
    always_comb begin
        logic fb;
        fb        = 1'b0;
        lfsr_next = lfsr_reg;
        prbs_word = '0;
        for (int i = 0; i < W; i++) begin
            unique case (p.code)
                PAT_PN31: fb = lfsr_next[30] ^ lfsr_next[27];
                PAT_PN23: fb = lfsr_next[22] ^ lfsr_next[17];
                PAT_PN15: fb = lfsr_next[14] ^ lfsr_next[13];
                PAT_PN9:  fb = lfsr_next[8] ^ lfsr_next[4];
                default:  fb = lfsr_next[6] ^ lfsr_next[5];
            endcase
            lfsr_next = {lfsr_next[29:0], fb};
            prbs_word = {prbs_word[W-2:0], fb};
        end
    end

    // ==========================================================
    // next word by pattern code
    always_comb begin
        unique case (p.code)
            PAT_CHECK:  word_next = ph_reg ? ~{(W/2){2'b10}} : {(W/2){2'b10}};
            PAT_TOGGLE: word_next = {W{ph_reg}};
            PAT_RAMP:   word_next = ramp_reg;
            PAT_USER_R, PAT_USER_1:
                word_next = W'(idx_reg ? p.user[31:16] : p.user[15:0]);
            PAT_PN31, PAT_PN23, PAT_PN15, PAT_PN9, PAT_PN7:
                word_next = prbs_word;
            default:    word_next = '0;
        endcase
    end

    // ==========================================================
    // generator state; restart reloads so a new code starts clean
    always_ff @(posedge mclk) begin
        if (!rst_n || p.restart) begin
            lfsr_reg <= PN_SEED;
            ph_reg   <= 1'b0;
            ramp_reg <= '0;
            idx_reg  <= 1'b0;
            done_reg <= 1'b0;
            sent_reg <= 1'b0;
            word_reg <= '0;
        end else if (p.step) begin
            lfsr_reg <= lfsr_next;
            ph_reg   <= ~ph_reg;
            ramp_reg <= ramp_reg + W'(1);
            idx_reg  <= ~idx_reg;
            word_reg <= word_next;
            if (p.code == PAT_USER_1) begin
                sent_reg <= sent_reg | idx_reg;
                done_reg <= sent_reg;
            end
        end
    end

    assign p.word = word_reg;

    // single user: word b is used one cycle after its step, so done lags one step
    always_comb begin
        unique case (p.code)
            PAT_CHECK, PAT_TOGGLE, PAT_RAMP, PAT_USER_R,
            PAT_PN31, PAT_PN23, PAT_PN15, PAT_PN9, PAT_PN7:
                p.active = 1'b1;
            PAT_USER_1: p.active = !done_reg;
            default:    p.active = 1'b0;
        endcase
    end
endmodule : test_pattern_gen

// >>> hw/link_coding_ctrl.sv
// Purpose: transmit link coding, checksum and test control behind AXI4-Lite
// Assumes: two octets per cycle, lane carries two 10-bit symbols
// Notes:   writes answer two cycles after both channels are taken
// Behaviour
// - bypass set: skip encoding, send octet with top two symbol bits zero
// - invert set: complement all ten symbol bits; clear: send symbols as they are
// - checksum mode 00: sum of all 8-bit configuration table bytes
// - checksum mode 01: sum of each configuration field aligned at its lsb
// - checksum mode 10 sends zero; code 11 unused, not to be programmed
// - injection 0 at sample input, 1 at encoder output, 2 at scrambler input
// - pattern code 0000 carries normal converter data, generation off
// - codes 0011 and 0100 send pn31 and pn23 sequences
// - codes 0101, 0110, 0111 send pn15, pn9 and pn7 sequences
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module link_coding_ctrl #(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // axi4-lite write
    input  wire logic [ADDR_W-1:0] s_awaddr,
    input  wire logic              s_awvalid,
    output logic                   s_awready,
    input  wire logic [31:0]       s_wdata,
    input  wire logic [3:0]        s_wstrb,
    input  wire logic              s_wvalid,
    output logic                   s_wready,
    output logic [1:0]             s_bresp,
    output logic                   s_bvalid,
    input  wire logic              s_bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] s_araddr,
    input  wire logic              s_arvalid,
    output logic                   s_arready,
    output logic [31:0]            s_rdata,
    output logic [1:0]             s_rresp,
    output logic                   s_rvalid,
    input  wire logic              s_rready,
    // converter samples
    input  wire logic [15:0]       sample_in,
    input  wire logic              sample_valid,
    // lane symbols, first symbol in the upper half
    output logic [19:0]            lane_data,
    output logic                   lane_valid,
    output logic [7:0]             checksum
);
    import link_test_pkg::*;

    pat_if #(.W(20)) pat ();

    logic [7:0]        ctrl2_reg, ctrl3_reg;
    logic [31:0]       cfg_reg, user_reg;
    logic              aw_rdy_reg, w_rdy_reg, aw_got_reg, w_got_reg, bvalid_reg;
    logic [13:0]       aw_idx_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic [1:0]        bresp_reg;
    logic              ar_rdy_reg, rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [1:0]        rresp_reg;
    logic [7:0]        csum_reg, csum_next;
    logic [15:0]       oct_reg;
    logic              oct_vld_reg;
    logic [19:0]       lane_reg;
    logic              lane_vld_reg;
    logic              rd_reg;
    logic              restart_reg;
    logic              do_write;

    // ==========================================================
    // 8b/10b data encoder, symbol abcdei_fghj with a in bit 9
    function automatic logic [10:0] enc_octet(input logic [7:0] d, input logic rd);
        logic [5:0] c6;
        logic [3:0] c4;
        logic       r;
        logic       alt;
        r = rd;
        unique case (d[4:0])
            5'h00: c6 = 6'h27; 5'h01: c6 = 6'h1d; 5'h02: c6 = 6'h2d; 5'h03: c6 = 6'h31;
            5'h04: c6 = 6'h35; 5'h05: c6 = 6'h29; 5'h06: c6 = 6'h19; 5'h07: c6 = 6'h38;
            5'h08: c6 = 6'h39; 5'h09: c6 = 6'h25; 5'h0a: c6 = 6'h15; 5'h0b: c6 = 6'h34;
            5'h0c: c6 = 6'h0d; 5'h0d: c6 = 6'h2c; 5'h0e: c6 = 6'h1c; 5'h0f: c6 = 6'h17;
            5'h10: c6 = 6'h1b; 5'h11: c6 = 6'h23; 5'h12: c6 = 6'h13; 5'h13: c6 = 6'h32;
            5'h14: c6 = 6'h0b; 5'h15: c6 = 6'h2a; 5'h16: c6 = 6'h1a; 5'h17: c6 = 6'h3a;
            5'h18: c6 = 6'h33; 5'h19: c6 = 6'h26; 5'h1a: c6 = 6'h16; 5'h1b: c6 = 6'h36;
            5'h1c: c6 = 6'h0e; 5'h1d: c6 = 6'h2e; 5'h1e: c6 = 6'h1e; default: c6 = 6'h2b;
        endcase
        // d.7 is balanced yet still flips with disparity
        if (r && ($countones(c6) != 3 || d[4:0] == 5'h07))
            c6 = ~c6;
        if ($countones(c6) != 3)
            r = ~r;
        // alternate d.x.7 avoids a run of five equal bits across the boundary
        alt = (!r && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14)) ||
              (r && (d[4:0] == 5'h0b || d[4:0] == 5'h0d || d[4:0] == 5'h0e));
        unique case (d[7:5])
            3'h0: c4 = 4'hb; 3'h1: c4 = 4'h9; 3'h2: c4 = 4'h5; 3'h3: c4 = 4'hc;
            3'h4: c4 = 4'hd; 3'h5: c4 = 4'ha; 3'h6: c4 = 4'h6;
            default: c4 = alt ? 4'h7 : 4'he;
        endcase
        if (r && ($countones(c4) != 2 || d[7:5] == 3'h3))
            c4 = ~c4;
        if ($countones(c4) != 2)
            r = ~r;
        return {r, c6, c4};
    endfunction : enc_octet

    // ==========================================================
    // write channel: address and data taken in either order
    assign do_write = aw_got_reg && w_got_reg && !bvalid_reg;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            aw_rdy_reg <= 1'b0;
            w_rdy_reg  <= 1'b0;
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            aw_idx_reg <= '0;
            wdata_reg  <= '0;
            wstrb_reg  <= '0;
        end else begin
            aw_rdy_reg <= !aw_got_reg && !(s_awvalid && aw_rdy_reg);
            w_rdy_reg  <= !w_got_reg && !(s_wvalid && w_rdy_reg);
            if (s_awvalid && aw_rdy_reg) begin
                aw_got_reg <= 1'b1;
                aw_idx_reg <= s_awaddr[15:2];
            end
            if (s_wvalid && w_rdy_reg) begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_wdata;
                wstrb_reg <= s_wstrb;
            end
            if (do_write) begin
                aw_got_reg <= 1'b0;
                w_got_reg  <= 1'b0;
                aw_rdy_reg <= 1'b0;
                w_rdy_reg  <= 1'b0;
            end
        end
    end

    // write response; unmapped indices are refused with decerr
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (aw_idx_reg inside {CTRL2_IDX, CTRL3_IDX, CFG_TAB_IDX, USER_PAT_IDX, CHKSUM_IDX})
                          ? RESP_OKAY : RESP_DECERR;
        end else if (s_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ==========================================================
    // register file; a write to the test control restarts the pattern source
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl2_reg   <= CTRL2_RST;
            ctrl3_reg   <= CTRL3_RST;
            cfg_reg     <= CFG_TAB_RST;
            user_reg    <= USER_PAT_RST;
            restart_reg <= 1'b1;
        end else begin
            restart_reg <= do_write && aw_idx_reg == CTRL3_IDX && wstrb_reg[0];
            if (do_write && wstrb_reg[0] && aw_idx_reg == CTRL2_IDX)
                ctrl2_reg <= {wdata_reg[7:4], 1'b0, wdata_reg[2:0]};
            if (do_write && wstrb_reg[0] && aw_idx_reg == CTRL3_IDX)
                ctrl3_reg <= wdata_reg[7:0];
            for (int b = 0; b < 4; b++) begin
                if (do_write && wstrb_reg[b] && aw_idx_reg == CFG_TAB_IDX)
                    cfg_reg[8*b +: 8] <= wdata_reg[8*b +: 8];
                if (do_write && wstrb_reg[b] && aw_idx_reg == USER_PAT_IDX)
                    user_reg[8*b +: 8] <= wdata_reg[8*b +: 8];
            end
        end
    end

    // ==========================================================
    // read channel, one read at a time
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ar_rdy_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end else if (s_arvalid && ar_rdy_reg) begin
            ar_rdy_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rresp_reg  <= RESP_OKAY;
            unique case (s_araddr[15:2])
                CTRL2_IDX:    rdata_reg <= {24'h000000, ctrl2_reg};
                CTRL3_IDX:    rdata_reg <= {24'h000000, ctrl3_reg};
                CFG_TAB_IDX:  rdata_reg <= cfg_reg;
                USER_PAT_IDX: rdata_reg <= user_reg;
                CHKSUM_IDX:   rdata_reg <= {23'h000000, pat.active, csum_reg};
                default: begin
                    rdata_reg <= '0;
                    rresp_reg <= RESP_DECERR;
                end
            endcase
        end else if (rvalid_reg && s_rready) begin
            rvalid_reg <= 1'b0;
            ar_rdy_reg <= 1'b1;
        end else begin
            ar_rdy_reg <= !rvalid_reg;
        end
    end

    // ==========================================================
    // checksum over the configuration table, modulo 256
    always_comb begin
        unique case (ctrl3_reg[CSUM_HI:CSUM_LO])
            CSUM_REGS:   csum_next = cfg_reg[7:0] + cfg_reg[15:8] + cfg_reg[23:16] + cfg_reg[31:24];
            CSUM_FIELDS: csum_next = cfg_reg[DID_LO +: 8] + 8'(cfg_reg[BID_LO +: 4]) +
                                     8'(cfg_reg[ADJ_LO +: 4]) + 8'(cfg_reg[LID_LO +: 5]) +
                                     8'(cfg_reg[SCR_BIT]) + 8'(cfg_reg[LCNT_LO +: 5]) +
                                     8'(cfg_reg[HD_BIT]);
            default:     csum_next = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n)
            csum_reg <= 8'h00;
        else
            csum_reg <= csum_next;
    end

    // ==========================================================
    // pattern source steps with the sample stream
    assign pat.code    = ctrl3_reg[PAT_HI:PAT_LO];
    assign pat.step    = sample_valid;
    assign pat.restart = restart_reg;
    assign pat.user    = user_reg;

    test_pattern_gen #(.W(20)) u_pat (
        .mclk  (mclk),
        .rst_n (rst_n),
        .p     (pat)
    );

    // stage one: sample register; injected words join in stage two, where the word lines up
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            oct_reg     <= '0;
            oct_vld_reg <= 1'b0;
        end else begin
            oct_vld_reg <= sample_valid;
            if (sample_valid)
                oct_reg <= sample_in;
        end
    end

    // stage two: scrambler input, encoder, bypass, symbol injection and inversion
    always_ff @(posedge mclk) begin
        logic [15:0] o;
        logic [10:0] e0, e1;
        logic [19:0] s;
        o  = (pat.active && ctrl3_reg[INJ_HI:INJ_LO] inside {INJ_SAMPLE, INJ_SCRAM}) ? pat.word[15:0] :
             oct_reg;
        e0 = enc_octet(o[15:8], rd_reg);
        e1 = enc_octet(o[7:0], e0[10]);
        s  = {e0[9:0], e1[9:0]};
        if (ctrl2_reg[BYPASS_BIT])
            s = {2'b00, o[15:8], 2'b00, o[7:0]};
        if (pat.active && ctrl3_reg[INJ_HI:INJ_LO] == INJ_SYMBOL)
            s = pat.word;
        if (!rst_n) begin
            lane_reg     <= '0;
            lane_vld_reg <= 1'b0;
            rd_reg       <= 1'b0;
        end else begin
            lane_vld_reg <= oct_vld_reg;
            if (oct_vld_reg) begin
                lane_reg <= ctrl2_reg[INVERT_BIT] ? ~s : s;
                if (!ctrl2_reg[BYPASS_BIT])
                    rd_reg <= e1[10];
            end
        end
    end

    // ==========================================================
    // outputs straight from flops
    assign s_awready  = aw_rdy_reg;
    assign s_wready   = w_rdy_reg;
    assign s_bvalid   = bvalid_reg;
    assign s_bresp    = bresp_reg;
    assign s_arready  = ar_rdy_reg;
    assign s_rvalid   = rvalid_reg;
    assign s_rdata    = rdata_reg;
    assign s_rresp    = rresp_reg;
    assign lane_data  = lane_reg;
    assign lane_valid = lane_vld_reg;
    assign checksum   = csum_reg;
endmodule : link_coding_ctrl

// >>> verification/lane_sink.sv
// Purpose: far-end receiver model
// Assumes: lane_valid marks one word
// Notes:   no back-pressure, never stalls
`timescale 1ns/10ps
module lane_sink (
    // lane side
    input  wire logic        mclk,
    input  wire logic        lane_valid,
    input  wire logic [19:0] lane_data
);
    logic [19:0] q[$];
    // ==========================================================
    // keep every valid word
    always @(posedge mclk) begin
        if (lane_valid) q.push_back(lane_data);
    end
endmodule : lane_sink

// >>> verification/link_coding_ctrl_chk.sv
// Purpose: port-level checks
// Assumes: one clock, sync low reset
// Notes:   top ports only
`timescale 1ns/10ps
module link_coding_ctrl_chk (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // register bus
    input wire logic        s_awvalid,
    input wire logic        s_awready,
    input wire logic        s_wvalid,
    input wire logic        s_wready,
    input wire logic [1:0]  s_bresp,
    input wire logic        s_bvalid,
    input wire logic        s_bready,
    input wire logic        s_arvalid,
    input wire logic        s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic        s_rvalid,
    input wire logic        s_rready,
    // stream
    input wire logic        sample_valid,
    input wire logic        lane_valid,
    input wire logic [19:0] lane_data
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // stream timing: fixed two-stage pipe, no back-pressure
    property p_lane_lat; sample_valid |-> ##2 lane_valid; endproperty
    a_lane_lat: assert property (p_lane_lat) else $error("lane word missing");
    property p_lane_gap; !sample_valid |-> ##2 !lane_valid; endproperty
    a_lane_gap: assert property (p_lane_gap) else $error("stray lane word");
    property p_lane_hold; !lane_valid |-> $stable(lane_data); endproperty
    a_lane_hold: assert property (p_lane_hold) else $error("idle lane moved");
    // ==========================================================
    // bus handshakes: answers stand until taken
    property p_b_hold; s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_rd_ans; s_arvalid && s_arready |=> s_rvalid && !s_arready; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    property p_aw_busy; s_awvalid && s_awready |=> !s_awready; endproperty
    a_aw_busy: assert property (p_aw_busy) else $error("aw taken twice");
    property p_wr_ans; s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
    c_wr: cover property (s_bvalid && s_bready);
    c_rd: cover property (s_rvalid && s_rready);
    c_lane: cover property (lane_valid [*2]);
endmodule : link_coding_ctrl_chk
bind link_coding_ctrl link_coding_ctrl_chk u_chk (.*);

// >>> verification/serial_link_coding_test_control_bench.sv
// Purpose: self-checking bench
// Assumes: bypass makes lane words predictable
// Notes:   pn words checked by recurrence
`timescale 1ns/10ps
module serial_link_coding_test_control_bench;
    import link_test_pkg::*;
    logic        mclk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, sample_valid, lane_valid;
    logic [15:0] awaddr, araddr, sample_in;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [19:0] lane_data;
    logic [7:0]  checksum;
    int          err_count, num_checks, cyc;
    link_coding_ctrl u_dut (.mclk(mclk), .rst_n(rst_n), .s_awaddr(awaddr), .s_awvalid(awvalid),
        .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
        .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
        .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
        .sample_in(sample_in), .sample_valid(sample_valid), .lane_data(lane_data),
        .lane_valid(lane_valid), .checksum(checksum));
    lane_sink u_sink (.mclk(mclk), .lane_valid(lane_valid), .lane_data(lane_data));
    always #2.5 mclk = ~mclk;
    // ==========================================================
    // shared tasks
    task end_sim;
        if (err_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [13:0] i, input logic [31:0] d, input logic [1:0] r);
        awaddr <= {i, 2'b00};
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, r});
    endtask : wr
    task rd(input logic [13:0] i, input logic [31:0] e, input logic [1:0] r);
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, r});
    endtask : rd
    task lane(input int i, input logic [19:0] e);
        chk({12'h0, u_sink.q[i]}, {12'h0, e});
    endtask : lane
    // wait out the pattern restart
    task c3(input logic [1:0] m, input logic [1:0] inj, input logic [3:0] p);
        wr(CTRL3_IDX, {24'h0, m, inj, p}, RESP_OKAY);
        repeat (3) @(posedge mclk);
    endtask : c3
    task stream(input int n, input logic [15:0] d);
        u_sink.q.delete();
        repeat (n) begin
            sample_valid <= 1'b1;
            sample_in <= d;
            @(posedge mclk);
        end
        sample_valid <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : stream
    function automatic logic [19:0] enc(input logic [15:0] v);
        return {2'b00, v[15:8], 2'b00, v[7:0]};
    endfunction : enc
    task run_pat(input logic [1:0] inj, input logic [3:0] p, input logic [19:0] e0, input logic [19:0] e1);
        c3(CSUM_REGS, inj, p);
        stream(2, 16'h1234);
        lane(0, e0);
        lane(1, e1);
    endtask : run_pat
    // ==========================================================
    // scenarios
    task t_regs;
        rd(CTRL2_IDX, {24'h0, CTRL2_RST}, RESP_OKAY);
        rd(CTRL3_IDX, {24'h0, CTRL3_RST}, RESP_OKAY);
        rd(14'h0100, 32'h0, RESP_DECERR);
        wr(14'h0100, 32'hff, RESP_DECERR);
    endtask : t_regs
    task t_code;
        wr(CTRL2_IDX, 32'h4, RESP_OKAY);
        stream(1, 16'ha55a);
        lane(0, enc(16'ha55a));
        wr(CTRL2_IDX, 32'he, RESP_OKAY);
        stream(1, 16'ha55a);
        lane(0, ~enc(16'ha55a));
        rd(CTRL2_IDX, 32'h6, RESP_OKAY);
    endtask : t_code
    task t_csum;
        wr(CFG_TAB_IDX, 32'h8a9c_35a7, RESP_OKAY);
        c3(CSUM_REGS, INJ_SAMPLE, PAT_OFF);
        chk({24'h0, checksum}, 32'h02);
        c3(CSUM_FIELDS, INJ_SAMPLE, PAT_OFF);
        chk({24'h0, checksum}, 32'hd7);
        c3(CSUM_ZERO, INJ_SAMPLE, PAT_OFF);
        chk({24'h0, checksum}, 32'h0);
        wr(CFG_TAB_IDX, 32'h0, RESP_OKAY);
    endtask : t_csum
    task t_pat;
        wr(CTRL2_IDX, 32'h4, RESP_OKAY);
        run_pat(INJ_SAMPLE, PAT_CHECK, enc(16'haaaa), enc(16'h5555));
        run_pat(INJ_SCRAM, PAT_CHECK, enc(16'haaaa), enc(16'h5555));
        run_pat(INJ_SYMBOL, PAT_TOGGLE, 20'h0, 20'hfffff);
        run_pat(INJ_SAMPLE, PAT_RAMP, enc(16'h0), enc(16'h1));
        run_pat(INJ_SAMPLE, PAT_OFF, enc(16'h1234), enc(16'h1234));
        wr(USER_PAT_IDX, 32'hbeef_1234, RESP_OKAY);
        run_pat(INJ_SYMBOL, PAT_USER_R, 20'h01234, 20'h0beef);
        c3(CSUM_REGS, INJ_SYMBOL, PAT_USER_1);
        stream(4, 16'h3c3c);
        lane(1, 20'h0beef);
        lane(2, enc(16'h3c3c));
    endtask : t_pat
    // pn bit stream must obey its recurrence
    task t_pn;
        int          n[5], k[5];
        logic [79:0] b;
        logic        ra, rb;
        n = '{31, 23, 15, 9, 7};
        k = '{28, 18, 14, 5, 6};
        wr(CTRL2_IDX, 32'h0, RESP_OKAY);
        for (int p = 0; p < 5; p++) begin
            c3(CSUM_REGS, INJ_SYMBOL, PAT_PN31 + 4'(p));
            stream(4, 16'h0);
            for (int t = 0; t < 80; t++) b[t] = u_sink.q[t / 20][19 - (t % 20)];
            ra = 1'b1;
            rb = 1'b1;
            for (int t = n[p]; t < 80; t++) begin
                ra &= !(b[t] ^ b[t - n[p]] ^ b[t - n[p] + k[p]]);
                rb &= !(b[t] ^ b[t - n[p]] ^ b[t - k[p]]);
            end
            chk({31'h0, (ra | rb) & (|b)}, 32'h1);
        end
    endtask : t_pn
    // ==========================================================
    // main sequence and hang guard
    initial begin
        {mclk, rst_n, awvalid, wvalid, bready, arvalid, rready, sample_valid} = '0;
        {awaddr, araddr, sample_in, wdata, wstrb} = '0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        t_regs;
        t_code;
        t_csum;
        t_pat;
        t_pn;
        end_sim;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_sim;
        end
    end
endmodule : serial_link_coding_test_control_bench
